// ---- dst_pkg.sv ----
// package of constants, carriers and helpers for the dma status tracking block
package dst_pkg;

    // ========================================
    // sizes
    localparam int unsigned NUM_CH  = 4;
    localparam int unsigned RAM_AW  = 24;
    localparam int unsigned PER_AW  = 16;
    localparam int unsigned REG_W   = 16;
    localparam int unsigned APB_AW  = 8;
    localparam int unsigned APB_DW  = 32;
    localparam int unsigned INT_W   = 8;

    // ========================================
    // register byte offsets
    localparam logic [7:0] OFF_ADDR_LO  = 8'h00;
    localparam logic [7:0] OFF_ADDR_HI  = 8'h04;
    localparam logic [7:0] OFF_PWC      = 8'h08;
    localparam logic [7:0] OFF_RQC      = 8'h0c;
    localparam logic [7:0] OFF_INT_STAT = 8'h10;
    localparam logic [7:0] OFF_INT_MASK = 8'h14;

    // ========================================
    // field positions
    localparam int unsigned ADDR_LO_MSB = 15;
    localparam int unsigned ADDR_HI_LSB = 16;
    localparam int unsigned ADDR_HI_MSB = 23;
    localparam int unsigned INT_PWC_LSB = 0;
    localparam int unsigned INT_RQC_LSB = 4;

    // ========================================
    // reset values
    localparam logic [23:0] RST_ADDR  = 24'h00_0000;
    localparam logic [3:0]  RST_FLAGS = 4'h0;
    localparam logic [7:0]  RST_INT   = 8'h00;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;

    // ========================================
    // carriers
    typedef struct packed {
        logic              valid;
        logic [RAM_AW-1:0] addr;
    } dst_ram_acc_s;

    typedef struct packed {
        logic              valid;
        logic [PER_AW-1:0] addr;
    } dst_periph_wr_s;

    // ========================================
    // helpers
    // true when the bus address names the given register word
    function automatic logic dst_hit(input logic [APB_AW-1:0] paddr, input logic [7:0] off);
        dst_hit = (paddr[APB_AW-1:2] == off[7:2]);
    endfunction : dst_hit

    // widen a 4-bit flag word to the bus width, upper bits zero
    function automatic logic [APB_DW-1:0] dst_flags32(input logic [3:0] f);
        dst_flags32 = {28'h000_0000, f};
    endfunction : dst_flags32

endpackage : dst_pkg

// ---- dst_sticky_flags.sv ----
// sticky flag bank: set pulses latch, clear pulses drop, set wins
`timescale 1ns/1ps
module dst_sticky_flags #(
    parameter int unsigned W = 4
) (
    input  wire logic         clk_in,
    input  wire logic         srst_in,
    input  wire logic [W-1:0] set_in,
    input  wire logic [W-1:0] clr_in,
    output logic      [W-1:0] flags_out
);

    // ========================================
    // flag storage
    logic [W-1:0] flags_reg;
    logic [W-1:0] flags_next;

    // clear first, then set, so a same-cycle event survives
    always_comb begin
        flags_next = (flags_reg & ~clr_in) | set_in;
    end

    // register stage
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign flags_out = flags_reg;

endmodule : dst_sticky_flags

// ---- dst_apb_port.sv ----
// apb answer stage: ready, read data and error straight from flip-flops
`timescale 1ns/1ps
module dst_apb_port (
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    input  wire logic        setup_in,
    input  wire logic [31:0] rdata_in,
    input  wire logic        err_in,
    output logic             pready_out,
    output logic      [31:0] prdata_out,
    output logic             pslverr_out
);

    // ========================================
    // answer registers
    logic        pready_reg;
    logic        pready_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        pslverr_reg;
    logic        pslverr_next;

    // answer is prepared during setup and shown for one access cycle
    always_comb begin
        pready_next  = setup_in;
        prdata_next  = setup_in ? rdata_in : dst_pkg::RST_RDATA;
        pslverr_next = setup_in & err_in;
    end

    // register stage
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= dst_pkg::RST_RDATA;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= pready_next;
            prdata_reg  <= prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign pready_out  = pready_reg;
    assign prdata_out  = prdata_reg;
    assign pslverr_out = pslverr_reg;

endmodule : dst_apb_port

// ---- dst_status_top.sv ----
// dma status tracking: last ram address, write and request clash flags, apb registers
//
// Summary of operation
// - capture low 16 address bits each access
// - keep address bits 23:16 in upper field
// - low address field read-only, zero after reset
// - channel n write clash at bit n
// - write clash flag reads one when detected
// - write clash flag zero until detected
// - bits 15:4 read zero, ignore writes
// - four write clash flags in one register
// - force and interrupt request clash sets flag
`timescale 1ns/1ps
module dst_status_top (
    input  wire logic                    clk_in,
    input  wire logic                    srst_in,
    input  wire logic                    psel_in,
    input  wire logic                    penable_in,
    input  wire logic                    pwrite_in,
    input  wire logic [7:0]              paddr_in,
    input  wire logic [31:0]             pwdata_in,
    output logic                         pready_out,
    output logic      [31:0]             prdata_out,
    output logic                         pslverr_out,
    input  wire dst_pkg::dst_ram_acc_s   ram_acc_in,
    input  wire dst_pkg::dst_periph_wr_s cpu_wr_in,
    input  wire dst_pkg::dst_periph_wr_s [3:0] dma_wr_in,
    input  wire logic [3:0]              force_req_in,
    input  wire logic [3:0]              irq_req_in,
    input  wire logic [3:0]              chan_reconfig_in,
    output logic                         irq_out
);

    // ========================================
    // declarations
    logic [23:0] last_addr_reg;
    logic [23:0] last_addr_next;
    logic [7:0]  int_mask_reg;
    logic [7:0]  int_mask_next;
    logic        irq_reg;
    logic        irq_next;
    logic [3:0]  pwc_set;
    logic [3:0]  rqc_set;
    logic [3:0]  pwc_flags;
    logic [3:0]  rqc_flags;
    logic [7:0]  int_set;
    logic [7:0]  int_clr;
    logic [7:0]  int_stat;
    logic        apb_setup;
    logic        apb_wr;
    logic [31:0] rdata_mux;
    logic        addr_err;

    // ========================================
    // last ram address capture
    // every dma access overwrites the full 24-bit address
    always_comb begin
        last_addr_next = last_addr_reg;
        if (ram_acc_in.valid) begin
            last_addr_next = ram_acc_in.addr;
        end
    end

    // register stage, zero after reset
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            last_addr_reg <= dst_pkg::RST_ADDR;
        end else begin
            last_addr_reg <= last_addr_next;
        end
    end

    // ========================================
    // clash detection
    // cpu and a channel hitting the same peripheral word in one cycle
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pwc_set[i] = cpu_wr_in.valid & dma_wr_in[i].valid
                         & (cpu_wr_in.addr == dma_wr_in[i].addr);
        end
    end

    // forced and interrupt request for one channel in one cycle
    assign rqc_set = force_req_in & irq_req_in;

    // write clash flags, held until the channel is reconfigured
    dst_sticky_flags #(
        .W(4)
    ) u_pwc_flags (
        .clk_in    (clk_in),
        .srst_in   (srst_in),
        .set_in    (pwc_set),
        .clr_in    (chan_reconfig_in),
        .flags_out (pwc_flags)
    );

    // request clash flags, same life cycle
    dst_sticky_flags #(
        .W(4)
    ) u_rqc_flags (
        .clk_in    (clk_in),
        .srst_in   (srst_in),
        .set_in    (rqc_set),
        .clr_in    (chan_reconfig_in),
        .flags_out (rqc_flags)
    );

    // ========================================
    // interrupt status, write one to clear
    assign int_set = {rqc_set, pwc_set};
    assign int_clr = (apb_wr && dst_pkg::dst_hit(paddr_in, dst_pkg::OFF_INT_STAT))
                     ? pwdata_in[7:0] : 8'h00;

    dst_sticky_flags #(
        .W(8)
    ) u_int_stat (
        .clk_in    (clk_in),
        .srst_in   (srst_in),
        .set_in    (int_set),
        .clr_in    (int_clr),
        .flags_out (int_stat)
    );

    // mask register and level interrupt
    always_comb begin
        int_mask_next = int_mask_reg;
        if (apb_wr && dst_pkg::dst_hit(paddr_in, dst_pkg::OFF_INT_MASK)) begin
            int_mask_next = pwdata_in[7:0];
        end
        irq_next = |(int_stat & int_mask_reg);
    end

    // register stage
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            int_mask_reg <= dst_pkg::RST_INT;
            irq_reg      <= 1'b0;
        end else begin
            int_mask_reg <= int_mask_next;
            irq_reg      <= irq_next;
        end
    end

    assign irq_out = irq_reg;

    // ========================================
    // apb decode
    // a write lands only on the edge that samples pready high
    assign apb_setup = psel_in & ~penable_in;
    assign apb_wr    = psel_in & penable_in & pwrite_in & pready_out;

    // read mux; address and clash registers are read-only, writes to them are dropped
    always_comb begin
        rdata_mux = dst_pkg::RST_RDATA;
        addr_err  = 1'b0;
        if (dst_pkg::dst_hit(paddr_in, dst_pkg::OFF_ADDR_LO)) begin
            rdata_mux = {16'h0000, last_addr_reg[dst_pkg::ADDR_LO_MSB:0]};
        end else if (dst_pkg::dst_hit(paddr_in, dst_pkg::OFF_ADDR_HI)) begin
            rdata_mux = {24'h00_0000,
                         last_addr_reg[dst_pkg::ADDR_HI_MSB:dst_pkg::ADDR_HI_LSB]};
        end else if (dst_pkg::dst_hit(paddr_in, dst_pkg::OFF_PWC)) begin
            rdata_mux = dst_pkg::dst_flags32(pwc_flags);
        end else if (dst_pkg::dst_hit(paddr_in, dst_pkg::OFF_RQC)) begin
            rdata_mux = dst_pkg::dst_flags32(rqc_flags);
        end else if (dst_pkg::dst_hit(paddr_in, dst_pkg::OFF_INT_STAT)) begin
            rdata_mux = {24'h00_0000, int_stat};
        end else if (dst_pkg::dst_hit(paddr_in, dst_pkg::OFF_INT_MASK)) begin
            rdata_mux = {24'h00_0000, int_mask_reg};
        end else begin
            addr_err  = 1'b1;
        end
        if (pwrite_in) begin
            rdata_mux = dst_pkg::RST_RDATA;
        end
    end

    // registered answer, zero wait states
    dst_apb_port u_apb_port (
        .clk_in      (clk_in),
        .srst_in     (srst_in),
        .setup_in    (apb_setup),
        .rdata_in    (rdata_mux),
        .err_in      (addr_err),
        .pready_out  (pready_out),
        .prdata_out  (prdata_out),
        .pslverr_out (pslverr_out)
    );

    // ========================================
    // assertions
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);

    // captured address follows the access one cycle later
    a_addr_capture: assert property (
        ram_acc_in.valid |=> last_addr_reg == $past(ram_acc_in.addr)
    ) else $error("last address not captured");

    // upper field holds while no access happens
    a_addr_hold: assert property (
        !ram_acc_in.valid |=> $stable(last_addr_reg[23:16])
    ) else $error("upper address changed without access");

    // reset clears the captured address
    a_addr_reset: assert property (
        @(posedge clk_in) disable iff (1'b0) srst_in |=> last_addr_reg == 24'h00_0000
    ) else $error("address not zero after reset");

    // a detected write clash is visible next cycle
    a_pwc_set: assert property (
        pwc_set != 4'h0 |=> (pwc_flags & $past(pwc_set)) == $past(pwc_set)
    ) else $error("write clash flag not set");

    // a flag with neither event nor reconfigure keeps its value
    a_pwc_hold: assert property (
        (chan_reconfig_in == 4'h0) && (pwc_set == 4'h0) |=> $stable(pwc_flags)
    ) else $error("write clash flag changed on its own");

    // reconfigure without a new event clears the channel flag
    a_pwc_clear: assert property (
        (chan_reconfig_in[0] && !pwc_set[0]) ##1 (pwc_set == 4'h0) |-> !pwc_flags[0]
    ) else $error("write clash flag not cleared");

    // a read of the write clash register shows the flags, upper bits zero
    a_pwc_read: assert property (
        apb_setup && !pwrite_in && dst_pkg::dst_hit(paddr_in, dst_pkg::OFF_PWC)
        |=> pready_out && prdata_out == {28'h000_0000, $past(pwc_flags)}
    ) else $error("write clash register read wrong");

    // a write to a read-only clash register leaves it alone
    a_ro_ignore: assert property (
        apb_wr && dst_pkg::dst_hit(paddr_in, dst_pkg::OFF_PWC) && (pwc_set == 4'h0)
        && (chan_reconfig_in == 4'h0) |=> $stable(pwc_flags)
    ) else $error("read-only register took a write");

    // colliding requests raise the request flag and the status bit
    a_rqc_set: assert property (
        (force_req_in[1] && irq_req_in[1]) |=> rqc_flags[1] && int_stat[5]
    ) else $error("request clash flag not set");

    // channel flag sits at its own bit position
    a_pwc_bitpos: assert property (
        pwc_set == 4'h8 && chan_reconfig_in == 4'h0 |=> pwc_flags[3]
    ) else $error("channel 3 flag misplaced");

    // interrupt follows masked status by one cycle
    a_irq_level: assert property (
        |(int_stat & int_mask_reg) |=> irq_out
    ) else $error("interrupt not raised");

    // every setup draws exactly one ready cycle
    a_ready_once: assert property (
        apb_setup |=> pready_out ##1 !pready_out
    ) else $error("ready not a single cycle");

    // low address word shows bits 15:0 of the capture, upper half zero
    a_addr_lo_read: assert property (
        apb_setup && !pwrite_in && dst_pkg::dst_hit(paddr_in, dst_pkg::OFF_ADDR_LO)
        |=> prdata_out == {16'h0000, $past(last_addr_reg[15:0])}
    ) else $error("low address register read wrong");

    // high address word shows bits 23:16 of the capture
    a_addr_hi_read: assert property (
        apb_setup && !pwrite_in && dst_pkg::dst_hit(paddr_in, dst_pkg::OFF_ADDR_HI)
        |=> prdata_out == {24'h00_0000, $past(last_addr_reg[23:16])}
    ) else $error("high address register read wrong");

    // request clash read shows the flags, upper bits zero
    a_rqc_read: assert property (
        apb_setup && !pwrite_in && dst_pkg::dst_hit(paddr_in, dst_pkg::OFF_RQC)
        |=> pready_out && prdata_out == {28'h000_0000, $past(rqc_flags)}
    ) else $error("request clash register read wrong");

    // writes to read-only clash words draw no error and no data
    a_ro_write_quiet: assert property (
        apb_wr && (dst_pkg::dst_hit(paddr_in, dst_pkg::OFF_PWC) || dst_pkg::dst_hit(paddr_in, dst_pkg::OFF_RQC))
        |-> !pslverr_out && prdata_out == dst_pkg::RST_RDATA
    ) else $error("read-only write answered wrongly");

    // unmapped words answer with an error and zero data
    a_bad_addr_err: assert property (
        apb_setup && (paddr_in[7:2] > dst_pkg::OFF_INT_MASK[7:2])
        |=> pready_out && pslverr_out && prdata_out == dst_pkg::RST_RDATA
    ) else $error("unmapped address not refused");

    // reset clears every clash flag and the interrupt status
    a_flags_reset: assert property (
        @(posedge clk_in) disable iff (1'b0)
        srst_in |=> pwc_flags == dst_pkg::RST_FLAGS && rqc_flags == dst_pkg::RST_FLAGS
        && int_stat == dst_pkg::RST_INT
    ) else $error("flags not zero after reset");

    // reset quiets every bus and interrupt output
    a_out_reset: assert property (
        @(posedge clk_in) disable iff (1'b0)
        srst_in |=> !pready_out && !pslverr_out && !irq_out && prdata_out == dst_pkg::RST_RDATA
    ) else $error("outputs not zero after reset");

    // reconfigure without a new event clears the request clash flag
    a_rqc_clear: assert property (
        (chan_reconfig_in & ~rqc_set) != 4'h0
        |=> (rqc_flags & $past(chan_reconfig_in) & ~$past(rqc_set)) == 4'h0
    ) else $error("request clash flag not cleared");

    // writing ones drops status bits that see no new event
    a_int_clear: assert property (
        apb_wr && dst_pkg::dst_hit(paddr_in, dst_pkg::OFF_INT_STAT)
        |=> (int_stat & $past(pwdata_in[7:0]) & ~$past(int_set)) == 8'h00
    ) else $error("status bit not cleared by write");

    // interrupt drops once nothing unmasked is pending
    a_irq_low: assert property (
        (int_stat & int_mask_reg) == 8'h00 |=> !irq_out
    ) else $error("interrupt high without cause");

endmodule : dst_status_top

// ---- dst_side_model.sv ----
// far-side model: dma ram accesses and cpu/dma peripheral writes
`timescale 1ns/1ps
module dst_side_model (
    input  wire logic                     clk_in,
    input  wire logic                     ram_go_in,
    input  wire logic [23:0]              ram_addr_in,
    input  wire logic [3:0]               same_in,
    input  wire logic [3:0]               diff_in,
    output dst_pkg::dst_ram_acc_s         ram_acc_out,
    output dst_pkg::dst_periph_wr_s       cpu_wr_out,
    output dst_pkg::dst_periph_wr_s [3:0] dma_wr_out
);
    logic [15:0] base_reg;
    initial begin
        base_reg = 16'h0000;
        ram_acc_out = '0;
        cpu_wr_out = '0;
        dma_wr_out = '0;
    end
    // ============================================
    // bus drive: idle address lines keep changing
    always @(posedge clk_in) begin
        base_reg <= base_reg + 16'h0013;
        ram_acc_out.valid <= ram_go_in;
        ram_acc_out.addr <= ram_go_in ? ram_addr_in : ~ram_acc_out.addr;
        cpu_wr_out.valid <= |(same_in | diff_in);
        cpu_wr_out.addr <= base_reg;
        for (int i = 0; i < 4; i++) begin
            dma_wr_out[i].valid <= same_in[i] | diff_in[i];
            dma_wr_out[i].addr <= same_in[i] ? base_reg : ~base_reg;
        end
    end
endmodule : dst_side_model

// ---- dst_status_tracking_tb.sv ----
// self-checking testbench for the dma status tracking block
`timescale 1ns/1ps
module dst_status_tracking_tb;
    logic clk_in = 1'b0, srst_in = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic pready, pslverr, irq, ram_go = 1'b0;
    logic [23:0] ram_addr = 24'h00_0000, a1, a2;
    logic [3:0] same = 4'h0, diff = 4'h0, frc = 4'h0, ireq = 4'h0, rcfg = 4'h0;
    logic [3:0] e_pwc = 4'h0, e_rqc = 4'h0;
    logic [7:0] e_int = 8'h00;
    logic [32:0] exp_q[$];
    dst_pkg::dst_ram_acc_s ram_acc;
    dst_pkg::dst_periph_wr_s cpu_wr;
    dst_pkg::dst_periph_wr_s [3:0] dma_wr;
    int err_total = 0, total_checks = 0, cyc = 0, seed = 19301;

    always #12.5 clk_in = ~clk_in;

    dst_status_top u_dst_status_top (.clk_in(clk_in), .srst_in(srst_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr), .ram_acc_in(ram_acc),
        .cpu_wr_in(cpu_wr), .dma_wr_in(dma_wr), .force_req_in(frc), .irq_req_in(ireq),
        .chan_reconfig_in(rcfg), .irq_out(irq));
    dst_side_model u_dst_side_model (.clk_in(clk_in), .ram_go_in(ram_go), .ram_addr_in(ram_addr),
        .same_in(same), .diff_in(diff), .ram_acc_out(ram_acc), .cpu_wr_out(cpu_wr),
        .dma_wr_out(dma_wr));

    // ============================================
    // checking and closing
    task automatic cmp(input logic [32:0] got, input logic [32:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp

    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    // answer watcher against the oldest note, plus hang guard
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (pready === 1'b1) begin
            if (exp_q.size() == 0) cmp({pslverr, prdata}, 33'h1_ffff_ffff, "unexpected answer");
            else cmp({pslverr, prdata}, exp_q.pop_front(), "apb answer");
        end
        if (cyc == 5000) begin
            err_total++;
            final_report();
        end
    end

    // ============================================
    // drivers
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic err);
        exp_q.push_back({err, exp});
        @(posedge clk_in);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do @(posedge clk_in); while (pready !== 1'b1);
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    // writes arrive via model one cycle later, so requests follow a cycle after
    task automatic side(input logic [3:0] s, input logic [3:0] d, input logic [3:0] f,
                        input logic [3:0] q, input logic [3:0] r);
        @(posedge clk_in);
        same <= s; diff <= d;
        @(posedge clk_in);
        same <= 4'h0; diff <= 4'h0; frc <= f; ireq <= q; rcfg <= r;
        @(posedge clk_in);
        frc <= 4'h0; ireq <= 4'h0; rcfg <= 4'h0;
        repeat (2) @(posedge clk_in);
    endtask : side

    task automatic flags;
        apb(1'b0, 8'h08, 32'h0, {28'h0, e_pwc}, 1'b0);
        apb(1'b0, 8'h0c, 32'h0, {28'h0, e_rqc}, 1'b0);
    endtask : flags

    // ============================================
    // main sequence
    initial begin
        repeat (16) @(posedge clk_in);
        srst_in <= 1'b0;
        for (int k = 0; k < 6; k++) apb(1'b0, 8'(k * 4), 32'h0, 32'h0, 1'b0);
        apb(1'b0, 8'h18, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 8'h1c, 32'hffff_ffff, 32'h0, 1'b1);
        for (int k = 0; k < 4; k++) apb(1'b1, 8'(k * 4), 32'hffff_ffff, 32'h0, 1'b0);
        for (int k = 0; k < 4; k++) apb(1'b0, 8'(k * 4), 32'h0, 32'h0, 1'b0);
        $display("test reset_and_readonly done");
        repeat (4) begin
            a1 = 24'($random(seed));
            a2 = 24'($random(seed));
            @(posedge clk_in);
            ram_go <= 1'b1; ram_addr <= a1;
            @(posedge clk_in);
            ram_addr <= a2;
            @(posedge clk_in);
            ram_go <= 1'b0;
            apb(1'b0, 8'h00, 32'h0, {16'h0, a2[15:0]}, 1'b0);
            apb(1'b0, 8'h04, 32'h0, {24'h0, a2[23:16]}, 1'b0);
        end
        $display("test last_address done");
        for (int i = 0; i < 4; i++) begin
            side(4'h0, 4'(1 << i), 4'h0, 4'h0, 4'h0);
            flags();
            side(4'(1 << i), 4'h0, 4'(1 << i), 4'h0, 4'h0);
            side(4'h0, 4'h0, 4'h0, 4'(1 << i), 4'h0);
            e_pwc[i] = 1'b1;
            e_int[i] = 1'b1;
            flags();
            side(4'h0, 4'h0, 4'(1 << i), 4'(1 << i), 4'h0);
            e_rqc[i] = 1'b1;
            e_int[4 + i] = 1'b1;
            flags();
        end
        $display("test clash_flags done");
        apb(1'b0, 8'h10, 32'h0, {24'h0, e_int}, 1'b0);
        cmp({32'h0, irq}, 33'h0, "irq while masked");
        apb(1'b1, 8'h14, 32'h0000_00ff, 32'h0, 1'b0);
        apb(1'b0, 8'h14, 32'h0, 32'h0000_00ff, 1'b0);
        repeat (2) @(posedge clk_in);
        cmp({32'h0, irq}, 33'h1, "irq unmasked");
        apb(1'b1, 8'h10, {24'h0, e_int}, 32'h0, 1'b0);
        e_int = 8'h00;
        apb(1'b0, 8'h10, 32'h0, 32'h0, 1'b0);
        repeat (2) @(posedge clk_in);
        cmp({32'h0, irq}, 33'h0, "irq after clear");
        $display("test interrupt done");
        side(4'h0, 4'h0, 4'h0, 4'h0, 4'hf);
        e_pwc = 4'h0;
        e_rqc = 4'h0;
        flags();
        side(4'h1, 4'h0, 4'h8, 4'h8, 4'h9);
        e_pwc = 4'h1;
        e_rqc = 4'h8;
        flags();
        e_int = 8'h81;
        apb(1'b0, 8'h10, 32'h0, {24'h0, e_int}, 1'b0);
        cmp({32'h0, irq}, 33'h1, "irq before reset");
        $display("test reconfigure done");
        srst_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        srst_in <= 1'b0;
        for (int k = 0; k < 6; k++) apb(1'b0, 8'(k * 4), 32'h0, 32'h0, 1'b0);
        cmp({32'h0, irq}, 33'h0, "irq after reset");
        $display("test mid_reset done");
        repeat (2) @(posedge clk_in);
        final_report();
    end
endmodule : dst_status_tracking_tb
